// ===== rtl/dpr_out_reg.sv
// Port data output latch
module dpr_out_reg
    import dpr_pkg::*;
#(
    parameter int WIDTH = 16
)
(
    // System clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Operation and candidate words
    input dpr_op_t op_in,
    input wire logic [WIDTH-1:0] wdata_in,
    input wire logic [WIDTH-1:0] rdata_in,
    // Held output word
    output logic [WIDTH-1:0] data_out
);

    // Output changes only on an enabled operation
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            data_out <= DOUT_RST[WIDTH-1:0]; // RULE23
        else
        begin
            case (op_in)
                DPR_READ: data_out <= rdata_in; // RULE1 RULE12
                DPR_WRITE: data_out <= wdata_in; // RULE2 RULE12
                DPR_CLEAR: data_out <= DOUT_RST[WIDTH-1:0]; // RULE11
                DPR_CLEAR_WRITE: data_out <= DOUT_RST[WIDTH-1:0]; // RULE22
                DPR_IDLE: data_out <= data_out; // RULE6 RULE9
                default: data_out <= data_out;
            endcase
        end
    end

endmodule : dpr_out_reg

// ===== rtl/dpr_pkg.sv
// Shared constants, types and helpers for the dual-port RAM
package dpr_pkg;

    // Array size and widest port
    localparam int MEM_BITS = 4096;
    localparam int ADDR_MAX = 12;
    localparam int DATA_MAX = 16;

    // System clock period in ns
    localparam int CLK_PERIOD_NS = 10;

    // Values after reset
    localparam logic CLK_PREV_RST = 1'b1;
    localparam logic [MEM_BITS-1:0] MEM_RST = '0;
    localparam logic [DATA_MAX-1:0] DOUT_RST = 16'h0000;

    // Operation taken at a port clock edge
    typedef enum {
        DPR_IDLE,
        DPR_READ,
        DPR_WRITE,
        DPR_CLEAR,
        DPR_CLEAR_WRITE
    } dpr_op_t;

    // One port request, padded to the widest port
    typedef struct packed {
        logic strobe;
        logic we;
        logic clr;
        logic [ADDR_MAX-1:0] addr;
        logic [DATA_MAX-1:0] data;
    } dpr_req_t;

    // Legal port widths
    function automatic bit dpr_width_ok(input int w);
        return (w == 1) || (w == 2) || (w == 4) || (w == 8) || (w == 16);
    endfunction : dpr_width_ok

    // Address width that a port width needs
    function automatic int dpr_addr_bits(input int w);
        case (w)
            2: return 11;
            4: return 10;
            8: return 9;
            16: return 8;
            default: return 12;
        endcase
    endfunction : dpr_addr_bits

    // First array bit of a word
    function automatic logic [ADDR_MAX-1:0] dpr_bit_base(input logic [ADDR_MAX-1:0] addr,
                                                         input int w);
        return ADDR_MAX'(int'(addr) * w);
    endfunction : dpr_bit_base

    // Operation selected by a request
    function automatic dpr_op_t dpr_decode(input dpr_req_t req);
        if (!req.strobe)
            return DPR_IDLE;
        else if (req.clr && req.we)
            return DPR_CLEAR_WRITE;
        else if (req.clr)
            return DPR_CLEAR;
        else if (req.we)
            return DPR_WRITE;
        else
            return DPR_READ;
    endfunction : dpr_decode

endpackage : dpr_pkg

// ===== rtl/dpr_port_front.sv
// Port front end: clock edge detection and control polarity
module dpr_port_front
    import dpr_pkg::*;
#(
    parameter bit INV_CLK = 1'b0,
    parameter bit INV_EN = 1'b0,
    parameter bit INV_WE = 1'b0,
    parameter bit INV_RST = 1'b0
)
(
    // System clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Port pins
    input wire logic port_clock_in,
    input wire logic enable_in,
    input wire logic write_en_in,
    input wire logic out_rst_in,
    input wire logic [ADDR_MAX-1:0] addr_in,
    input wire logic [DATA_MAX-1:0] data_in,
    // Decoded request
    output dpr_req_t req_out
);

    logic lvl;
    logic prev_r;

    // Port clock after its polarity option
    assign lvl = port_clock_in ^ INV_CLK; // RULE14

    // Previous port clock level
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            prev_r <= CLK_PREV_RST;
        else
            prev_r <= lvl;
    end

    // Inputs sampled only at this port's rising edge
    assign req_out.strobe = lvl & ~prev_r & (enable_in ^ INV_EN); // RULE3 RULE9 RULE14
    assign req_out.we = write_en_in ^ INV_WE; // RULE14 RULE19
    assign req_out.clr = out_rst_in ^ INV_RST; // RULE14
    assign req_out.addr = addr_in;
    assign req_out.data = data_in;

endmodule : dpr_port_front

// ===== rtl/dpr_ram.sv
// True dual-port 4096-bit RAM with per-port width
//
// The plain strobed port and the register addresses were chosen for this implementation.

// Function
// [RULE1] Read takes address at port edge, output valid after that one edge.
// [RULE2] Write stores input word and mirrors it on that port's output.
// [RULE3] All port inputs sampled only at that port's own rising clock edge.
// [RULE4] No combinational path from address to output; output changes only when clocked.
// [RULE5] Ports independent in clock, control, address, direction and width; no arbitration.
// [RULE6] Output holds, glitch free, until that port's next read or write.
// [RULE7] Both ports share one array of 4096 bits.
// [RULE8] Widths 1,2,4,8,16 give depths 4096 down to 256, addresses 12 to 8 bits.
// [RULE9] Disabled port neither writes nor changes nor clears its output.
// [RULE10] Enabled write stores and mirrors; enabled non-write reads.
// [RULE11] Output reset zeroes that port's output only, synchronously.
// [RULE12] Output shows cells of last enabled edge, or input data on a write.
// [RULE13] Data input is exactly port width; only that many bits written.
// [RULE14] Clock, enable, write enable and reset each have a polarity option.
// [RULE15] Width W at address A covers bits A*W to (A+1)*W-1.
// [RULE16] Other logic must not touch a cell being written within the window.
// [RULE17] Same-cell writes from both ports leave the cell undefined.
// [RULE18] Read against write: write succeeds, writer output right, reader undefined.
// [RULE19] Default polarity: enable high, write low reads; both high writes.
// [RULE20] Write by one port leaves other port's old read output in place.
// [RULE21] Array cells start as zero.
// [RULE22] Output reset with write still writes array, output forced to zero.
// [RULE23] Outputs read zero before any enabled operation.
module dpr_ram
    import dpr_pkg::*;
#(
    parameter int WIDTH_A = 16,
    parameter int WIDTH_B = 16,
    parameter bit INV_CLK_A = 1'b0,
    parameter bit INV_EN_A = 1'b0,
    parameter bit INV_WE_A = 1'b0,
    parameter bit INV_RST_A = 1'b0,
    parameter bit INV_CLK_B = 1'b0,
    parameter bit INV_EN_B = 1'b0,
    parameter bit INV_WE_B = 1'b0,
    parameter bit INV_RST_B = 1'b0,
    parameter int ADDR_W_A = dpr_addr_bits(WIDTH_A),
    parameter int ADDR_W_B = dpr_addr_bits(WIDTH_B)
)
(
    // System clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Port A
    input wire logic port_a_clock_in,
    input wire logic port_a_enable_in,
    input wire logic port_a_write_en_in,
    input wire logic port_a_out_rst_in,
    input wire logic [ADDR_W_A-1:0] port_a_addr_in,
    input wire logic [WIDTH_A-1:0] port_a_data_in,
    output logic [WIDTH_A-1:0] port_a_data_out,
    // Port B
    input wire logic port_b_clock_in,
    input wire logic port_b_enable_in,
    input wire logic port_b_write_en_in,
    input wire logic port_b_out_rst_in,
    input wire logic [ADDR_W_B-1:0] port_b_addr_in,
    input wire logic [WIDTH_B-1:0] port_b_data_in,
    output logic [WIDTH_B-1:0] port_b_data_out
);

    // Refuse widths the array cannot map
    if (!dpr_width_ok(WIDTH_A) || !dpr_width_ok(WIDTH_B))
    begin : g_bad_width
        $error("dpr_ram: port width must be 1, 2, 4, 8 or 16"); // RULE8
    end
    if (ADDR_W_A != dpr_addr_bits(WIDTH_A) || ADDR_W_B != dpr_addr_bits(WIDTH_B))
    begin : g_bad_addr
        $error("dpr_ram: address width does not match port width"); // RULE8
    end

    logic [MEM_BITS-1:0] mem_r;
    dpr_req_t a_req;
    dpr_req_t b_req;
    dpr_op_t a_op;
    dpr_op_t b_op;
    logic [ADDR_MAX-1:0] a_base;
    logic [ADDR_MAX-1:0] b_base;
    logic [WIDTH_A-1:0] a_rdata;
    logic [WIDTH_B-1:0] b_rdata;

    // Port A front end
    dpr_port_front #(
        .INV_CLK(INV_CLK_A),
        .INV_EN(INV_EN_A),
        .INV_WE(INV_WE_A),
        .INV_RST(INV_RST_A)
    ) u_front_a (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .port_clock_in(port_a_clock_in),
        .enable_in(port_a_enable_in),
        .write_en_in(port_a_write_en_in),
        .out_rst_in(port_a_out_rst_in),
        .addr_in(ADDR_MAX'(port_a_addr_in)),
        .data_in(DATA_MAX'(port_a_data_in)),
        .req_out(a_req)
    );

    // Port B front end
    dpr_port_front #(
        .INV_CLK(INV_CLK_B),
        .INV_EN(INV_EN_B),
        .INV_WE(INV_WE_B),
        .INV_RST(INV_RST_B)
    ) u_front_b (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .port_clock_in(port_b_clock_in),
        .enable_in(port_b_enable_in),
        .write_en_in(port_b_write_en_in),
        .out_rst_in(port_b_out_rst_in),
        .addr_in(ADDR_MAX'(port_b_addr_in)),
        .data_in(DATA_MAX'(port_b_data_in)),
        .req_out(b_req)
    );

    // Operation and bit position of each port
    assign a_op = dpr_decode(a_req); // RULE10 RULE19
    assign b_op = dpr_decode(b_req); // RULE5 RULE10 RULE19
    assign a_base = dpr_bit_base(a_req.addr, WIDTH_A); // RULE15
    assign b_base = dpr_bit_base(b_req.addr, WIDTH_B); // RULE15

    // Words currently stored at each port's address
    assign a_rdata = mem_r[a_base +: WIDTH_A]; // RULE7 RULE15
    assign b_rdata = mem_r[b_base +: WIDTH_B]; // RULE7 RULE15

    // Shared array; on a same-cell clash port B lands last
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            mem_r <= MEM_RST; // RULE21
        else
        begin
            if (a_req.strobe && a_req.we)
                mem_r[a_base +: WIDTH_A] <= a_req.data[WIDTH_A-1:0]; // RULE13 RULE22
            if (b_req.strobe && b_req.we)
                mem_r[b_base +: WIDTH_B] <= b_req.data[WIDTH_B-1:0]; // RULE13 RULE17
        end
    end

    // Port A output latch
    dpr_out_reg #(
        .WIDTH(WIDTH_A)
    ) u_out_a (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .op_in(a_op),
        .wdata_in(a_req.data[WIDTH_A-1:0]),
        .rdata_in(a_rdata),
        .data_out(port_a_data_out)
    );

    // Port B output latch, old read kept across port A writes
    dpr_out_reg #(
        .WIDTH(WIDTH_B)
    ) u_out_b (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .op_in(b_op),
        .wdata_in(b_req.data[WIDTH_B-1:0]),
        .rdata_in(b_rdata),
        .data_out(port_b_data_out)
    ); // RULE18 RULE20

    // True when a word starting at lo_a begins inside the word at lo_b
    function automatic logic starts_inside(input logic [ADDR_MAX-1:0] lo_a,
                                           input logic [ADDR_MAX-1:0] lo_b,
                                           input int w_b);
        return (lo_a >= lo_b) && (int'(lo_a) < int'(lo_b) + w_b);
    endfunction : starts_inside

    // Helper: same-edge overlap of the two ports
    logic a_lo_in_b;
    logic b_lo_in_a;
    logic overlap;
    logic ww_clash;
    assign a_lo_in_b = starts_inside(a_base, b_base, WIDTH_B);
    assign b_lo_in_a = starts_inside(b_base, a_base, WIDTH_A);
    assign overlap = a_req.strobe && b_req.strobe && (a_lo_in_b || b_lo_in_a);
    // Only a write on B can override A's word; a read on B leaves it intact
    assign ww_clash = overlap && b_req.we; // RULE17 RULE18

    // Sequences used by the checks
    sequence a_plain_read_s;
        a_op == DPR_READ;
    endsequence

    sequence a_plain_write_s;
        a_op == DPR_WRITE;
    endsequence

    sequence b_plain_read_s;
        b_op == DPR_READ;
    endsequence

    sequence b_plain_write_s;
        b_op == DPR_WRITE;
    endsequence

    sequence a_idle_then_idle_s;
        (a_op == DPR_IDLE) ##1 (a_op == DPR_IDLE);
    endsequence

    sequence b_idle_then_idle_s;
        (b_op == DPR_IDLE) ##1 (b_op == DPR_IDLE);
    endsequence

    sequence a_clear_alone_s;
        (a_op == DPR_CLEAR) && (b_op == DPR_IDLE);
    endsequence

    sequence b_clear_alone_s;
        (b_op == DPR_CLEAR) && (a_op == DPR_IDLE);
    endsequence

    // Read on A lands on the output one cycle later
    chk_a_read_data: // RULE1 RULE12
    assert property (@(posedge clk_in) disable iff (rst_in)
        a_plain_read_s |=> port_a_data_out == $past(a_rdata))
    else
        $error("port A read data wrong");

    // Read on B lands on the output one cycle later
    chk_b_read_data: // RULE1 RULE5
    assert property (@(posedge clk_in) disable iff (rst_in)
        b_plain_read_s |=> port_b_data_out == $past(b_rdata))
    else
        $error("port B read data wrong");

    // Write on A mirrors the input word
    chk_a_write_mirror: // RULE2 RULE10
    assert property (@(posedge clk_in) disable iff (rst_in)
        a_plain_write_s |=> port_a_data_out == $past(a_req.data[WIDTH_A-1:0]))
    else
        $error("port A write not mirrored");

    // Write on B mirrors the input word even against a clash
    chk_b_write_mirror: // RULE2 RULE18
    assert property (@(posedge clk_in) disable iff (rst_in)
        b_plain_write_s |=> port_b_data_out == $past(b_req.data[WIDTH_B-1:0]))
    else
        $error("port B write not mirrored");

    // Write on A reaches the array unless port B writes over the same word
    chk_a_write_store: // RULE7 RULE13 RULE15
    assert property (@(posedge clk_in) disable iff (rst_in)
        (a_req.strobe && a_req.we && !ww_clash)
            |=> mem_r[$past(a_base) +: WIDTH_A] == $past(a_req.data[WIDTH_A-1:0]))
    else
        $error("port A write not stored");

    // Write on B reaches the array
    chk_b_write_store: // RULE7 RULE13 RULE17
    assert property (@(posedge clk_in) disable iff (rst_in)
        (b_req.strobe && b_req.we)
            |=> mem_r[$past(b_base) +: WIDTH_B] == $past(b_req.data[WIDTH_B-1:0]))
    else
        $error("port B write not stored");

    // Idle port A keeps its output for two cycles
    chk_a_idle_hold: // RULE6 RULE9
    assert property (@(posedge clk_in) disable iff (rst_in)
        a_idle_then_idle_s |-> $stable(port_a_data_out) ##1 $stable(port_a_data_out))
    else
        $error("port A output moved while idle");

    // Idle port B keeps its output for two cycles
    chk_b_idle_hold: // RULE6 RULE9
    assert property (@(posedge clk_in) disable iff (rst_in)
        b_idle_then_idle_s |-> $stable(port_b_data_out) ##1 $stable(port_b_data_out))
    else
        $error("port B output moved while idle");

    // Output B moves only after an enabled edge on B
    chk_b_no_comb: // RULE4 RULE20
    assert property (@(posedge clk_in) disable iff (rst_in)
        !$stable(port_b_data_out) |-> $past(b_req.strobe))
    else
        $error("port B output moved without its edge");

    // Output A moves only after an enabled edge on A
    chk_a_no_comb: // RULE4
    assert property (@(posedge clk_in) disable iff (rst_in)
        !$stable(port_a_data_out) |-> $past(a_req.strobe))
    else
        $error("port A output moved without its edge");

    // Write on B leaves the last read on A in place
    chk_a_keeps_read: // RULE20
    assert property (@(posedge clk_in) disable iff (rst_in)
        (b_op == DPR_WRITE && a_op == DPR_IDLE) |=> $stable(port_a_data_out))
    else
        $error("port A output moved on a port B write");

    // Write on A leaves the last read on B in place
    chk_b_keeps_read: // RULE20
    assert property (@(posedge clk_in) disable iff (rst_in)
        (a_op == DPR_WRITE && b_op == DPR_IDLE) |=> $stable(port_b_data_out))
    else
        $error("port B output moved on a port A write");

    // Output reset on A clears only A's output
    chk_a_out_clear: // RULE11
    assert property (@(posedge clk_in) disable iff (rst_in)
        a_clear_alone_s
            |=> port_a_data_out == '0 && $stable(port_b_data_out) && $stable(mem_r))
    else
        $error("port A output reset misbehaved");

    // Output reset on B clears only B's output
    chk_b_out_clear: // RULE11
    assert property (@(posedge clk_in) disable iff (rst_in)
        b_clear_alone_s
            |=> port_b_data_out == '0 && $stable(port_a_data_out) && $stable(mem_r))
    else
        $error("port B output reset misbehaved");

    // Output reset with a write still stores the word
    chk_a_clear_write: // RULE22
    assert property (@(posedge clk_in) disable iff (rst_in)
        (a_op == DPR_CLEAR_WRITE && !ww_clash)
            |=> port_a_data_out == '0
                && mem_r[$past(a_base) +: WIDTH_A] == $past(a_req.data[WIDTH_A-1:0]))
    else
        $error("port A reset with write misbehaved");

    // Output reset with a write on B still stores the word
    chk_b_clear_write: // RULE22
    assert property (@(posedge clk_in) disable iff (rst_in)
        (b_op == DPR_CLEAR_WRITE)
            |=> port_b_data_out == '0
                && mem_r[$past(b_base) +: WIDTH_B] == $past(b_req.data[WIDTH_B-1:0]))
    else
        $error("port B reset with write misbehaved");

    // Disabled ports never write the array
    chk_idle_array_hold: // RULE9
    assert property (@(posedge clk_in) disable iff (rst_in)
        (!a_req.strobe && !b_req.strobe) |=> $stable(mem_r))
    else
        $error("array changed with both ports idle");

    // Both port outputs zero right after reset
    chk_a_reset_zero: // RULE23
    assert property (@(posedge clk_in)
        $fell(rst_in) |-> port_a_data_out == '0 && port_b_data_out == '0)
    else
        $error("outputs not zero after reset");

endmodule : dpr_ram

// ===== verification/dpr_port_drv.sv
// User-logic model that drives one RAM port from the system clock
module dpr_port_drv
    import dpr_pkg::*;
#(
    parameter int AW = 8,
    parameter int DW = 16
)
(
    // System clock
    input wire logic clk_in,
    // Port pins toward the RAM
    output logic pclk_out,
    output logic en_out,
    output logic we_out,
    output logic rst_out,
    output logic [AW-1:0] addr_out,
    output logic [DW-1:0] data_out
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle levels: port clock low, port disabled
    initial
    begin
        pclk_out = 1'b0;
        en_out = 1'b0;
        we_out = 1'b0;
        rst_out = 1'b0;
        addr_out = '0;
        data_out = '0;
    end

    // Low phase, high phase with the request, then release with inverted lines
    // Each call ends before the next begins, so no cell is touched mid-write
    task automatic op(input bit clk_edge, input bit en, input bit we, input bit rst,
                      input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clk_in);
        pclk_out <= 1'b0;
        @(posedge clk_in);
        pclk_out <= clk_edge;
        en_out <= en;
        we_out <= we;
        rst_out <= rst;
        addr_out <= a;
        data_out <= d;
        @(posedge clk_in);
        pclk_out <= 1'b0;
        en_out <= 1'b0;
        we_out <= ~we;
        rst_out <= ~rst;
        addr_out <= ~a;
        data_out <= ~d;
        @(posedge clk_in);
    endtask : op

endmodule : dpr_port_drv

// ===== verification/tb_dual_port_block_ram.sv
// Self-checking bench: 4-bit port A against 16-bit port B on one array
module tb_dual_port_block_ram
    import dpr_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk_in;
    logic rst_in;
    logic pa_clk, pa_en, pa_we, pa_rst;
    logic [9:0] pa_addr;
    logic [3:0] pa_data, pa_q, exp_a;
    logic pb_clk, pb_en, pb_we, pb_rst;
    logic [7:0] pb_addr;
    logic [15:0] pb_data, pb_q, exp_b;
    logic [MEM_BITS-1:0] mem;
    int n_errors = 0;
    int check_count = 0;
    int p;

    // Design and the two port drivers
    dpr_ram #(.WIDTH_A(4), .WIDTH_B(16)) uut (
        .clk_in(clk_in), .rst_in(rst_in),
        .port_a_clock_in(pa_clk), .port_a_enable_in(pa_en), .port_a_write_en_in(pa_we),
        .port_a_out_rst_in(pa_rst), .port_a_addr_in(pa_addr), .port_a_data_in(pa_data),
        .port_a_data_out(pa_q),
        .port_b_clock_in(pb_clk), .port_b_enable_in(pb_en), .port_b_write_en_in(pb_we),
        .port_b_out_rst_in(pb_rst), .port_b_addr_in(pb_addr), .port_b_data_in(pb_data),
        .port_b_data_out(pb_q));
    dpr_port_drv #(.AW(10), .DW(4)) drv_a (.clk_in(clk_in), .pclk_out(pa_clk),
        .en_out(pa_en), .we_out(pa_we), .rst_out(pa_rst), .addr_out(pa_addr),
        .data_out(pa_data));
    dpr_port_drv drv_b (.clk_in(clk_in), .pclk_out(pb_clk),
        .en_out(pb_en), .we_out(pb_we), .rst_out(pb_rst), .addr_out(pb_addr),
        .data_out(pb_data));

    // Verdict and end of run
    task automatic close_out();
        if (n_errors == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : close_out

    // Output word comparison
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Reference: bit array addressed as A*W .. A*W+W-1
    task automatic model(input int port, input bit ce, input bit en, input bit we,
                         input bit rst, input int a, input logic [15:0] d);
        int w;
        logic [15:0] q;
        w = (port == 1) ? 16 : 4;
        q = '0;
        if (!(ce && en))
            return;
        for (int i = 0; i < w; i++)
        begin
            if (we)
                mem[a * w + i] = d[i];
            q[i] = mem[a * w + i];
        end
        if (rst)
            q = '0;
        if (port == 1)
            exp_b = q;
        else
            exp_a = q[3:0];
    endtask : model

    // One operation on one port, then both outputs compared
    task automatic run(input int port, input bit ce, input bit en, input bit we,
                       input bit rst, input int a, input logic [15:0] d);
        if (port == 1)
            drv_b.op(ce, en, we, rst, a[7:0], d);
        else
            drv_a.op(ce, en, we, rst, a[9:0], d[3:0]);
        model(port, ce, en, we, rst, a, d);
        #1;
        chk({12'h000, pa_q}, {12'h000, exp_a});
        chk(pb_q, exp_b);
    endtask : run

    // System clock
    initial
    begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    // Watchdog
    initial
    begin
        #200000;
        n_errors++;
        close_out();
    end

    // Main sequence
    initial
    begin
        rst_in = 1'b1;
        mem = '0;
        exp_a = '0;
        exp_b = '0;
        repeat (16) @(posedge clk_in);
        rst_in <= 1'b0;
        void'($urandom(98145));
        #1;
        chk({12'h000, pa_q}, 16'h0000);
        chk(pb_q, 16'h0000);
        // Unwritten array reads zero
        run(1, 1, 1, 0, 0, 3, 16'h0000);
        // Wide write seen through narrow nibbles
        run(1, 1, 1, 1, 0, 0, 16'ha5c3);
        for (int i = 0; i < 4; i++)
            run(0, 1, 1, 0, 0, i, 16'h0000);
        // Disabled edge, then enabled request with no port edge
        run(0, 1, 0, 1, 0, 0, 16'h000f);
        run(0, 0, 1, 1, 0, 0, 16'h000e);
        // Output reset with write, then with read
        run(0, 1, 1, 1, 1, 2, 16'h0009);
        run(1, 1, 1, 0, 0, 0, 16'h0000);
        run(1, 1, 1, 0, 1, 0, 16'h0000);
        // Both ports on one edge, different cells
        fork
            drv_a.op(1, 1, 1, 0, 10'h008, 4'h6);
            drv_b.op(1, 1, 0, 0, 8'h00, 16'h0000);
        join
        model(0, 1, 1, 1, 0, 8, 16'h0006);
        model(1, 1, 1, 0, 0, 0, 16'h0000);
        #1;
        chk({12'h000, pa_q}, {12'h000, exp_a});
        chk(pb_q, exp_b);
        // Write against read of the same cell: writer output exact
        fork
            drv_a.op(1, 1, 1, 0, 10'h000, 4'h7);
            drv_b.op(1, 1, 0, 0, 8'h00, 16'h0000);
        join
        model(0, 1, 1, 1, 0, 0, 16'h0007);
        #1;
        chk({12'h000, pa_q}, {12'h000, exp_a});
        run(1, 1, 1, 0, 0, 0, 16'h0000);
        // Write against write: both outputs mirror their inputs
        fork
            drv_a.op(1, 1, 1, 0, 10'h001, 4'h3);
            drv_b.op(1, 1, 1, 0, 8'h00, 16'h1234);
        join
        model(1, 1, 1, 1, 0, 0, 16'h1234);
        model(0, 1, 1, 1, 0, 1, 16'h0003);
        mem[7:4] = 4'hx;
        #1;
        chk({12'h000, pa_q}, {12'h000, exp_a});
        chk(pb_q, exp_b);
        run(0, 1, 1, 1, 0, 1, 16'h000c);
        // Random traffic over overlapping cells
        for (int n = 0; n < 300; n++)
        begin
            p = $urandom % 2;
            run(p, ($urandom % 16) != 0, ($urandom % 8) != 0, $urandom % 2,
                ($urandom % 8) == 0, (p == 1) ? $urandom % 4 : $urandom % 16,
                16'($urandom));
        end
        close_out();
    end

endmodule : tb_dual_port_block_ram
